/* File: design/gyro_corr_pkg.sv */
// shared constants for the rate sensor bias correction and alarm block
package gyro_corr_pkg;
	// data and bus widths
	localparam int DATA_W      = 16;
	localparam int ADDR_W      = 7;
	localparam int BYTE_W      = 8;
	localparam int FRAME_BITS  = 16;
	localparam int BITCNT_W    = 5;
	localparam int COUNT_W     = 8;
	localparam int DEC_W       = 5;
	localparam int AVG_W       = 17;
	localparam int SRC_W       = 4;
	localparam int NUM_ALARMS  = 2;

	// register byte addresses (lower byte; upper byte is address plus one)
	localparam logic [6:0] OFS_OFFSET_FINE   = 7'h08;
	localparam logic [6:0] OFS_OFFSET_COARSE = 7'h0A;
	localparam logic [6:0] OFS_THRESHOLD1    = 7'h10;
	localparam logic [6:0] OFS_THRESHOLD2    = 7'h12;
	localparam logic [6:0] OFS_SAMPLES1      = 7'h14;
	localparam logic [6:0] OFS_SAMPLES2      = 7'h16;
	localparam logic [6:0] OFS_ALARM_CONFIG  = 7'h18;
	localparam logic [6:0] OFS_STATUS        = 7'h26;
	localparam logic [6:0] OFS_COMMAND       = 7'h28;

	// reset values
	localparam logic [15:0] REG_RESET = 16'h0000;

	// frame layout
	localparam int FRAME_RW_BIT   = 15;
	localparam int FRAME_ADDR_LSB = 8;

	// command trigger bits
	localparam int CMD_AUTO_NULL = 0;
	localparam int CMD_RESTORE   = 1;

	// alarm configuration fields
	localparam int CFG_SRC2_LSB = 12;
	localparam int CFG_SRC1_LSB = 8;
	localparam int CFG_ROC_LSB  = 6;
	localparam int CFG_POL_LSB  = 4;
	localparam int CFG_FILTER   = 3;
	localparam int CFG_IND_EN   = 2;
	localparam int CFG_IND_POL  = 1;
	localparam int CFG_IND_SEL  = 0;

	// alarm source codes
	localparam logic [3:0] SRC_OFF    = 4'h0;
	localparam logic [3:0] SRC_RATE   = 4'h1;
	localparam logic [3:0] SRC_TEMP   = 4'h2;
	localparam logic [3:0] SRC_STATUS = 4'h3;

	// status word alarm flag field
	localparam int STATUS_ALARM_LSB = 8;

	// decimation limit
	localparam logic [4:0] DEC_MAX = 5'h10;

	// auto null sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ALIGN,
		ST_COLLECT,
		ST_CAPTURE,
		ST_FLASH
	} null_state_e;
endpackage

/* File: design/alarm_channel.sv */
// one alarm comparator with static and rate-of-change modes
`timescale 1ns/1ns
`default_nettype none
module alarm_channel (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// sample stream
	input  wire logic        i_sample_stb,
	input  wire logic [15:0] i_value,
	// settings
	input  wire logic        i_enable,
	input  wire logic        i_roc,
	input  wire logic        i_above,
	input  wire logic [15:0] i_threshold,
	input  wire logic [7:0]  i_count,
	// result
	output logic             o_active,
	output logic             o_hit_stb
);
	localparam int DEPTH = 1 << gyro_corr_pkg::COUNT_W;

	logic [15:0] history [0:DEPTH-1];
	logic [7:0]  wr_ptr_reg;
	logic [7:0]  fill_reg;

	wire  [7:0]         span;
	wire  [7:0]         rd_ptr;
	wire  [15:0]        past;
	wire  signed [16:0] delta;
	wire  signed [16:0] level;
	wire  signed [16:0] limit;
	wire  signed [16:0] compared;
	wire                history_ok;
	wire                trip;
	wire                hit;

	assign span       = (i_count == 8'h00) ? 8'h01 : i_count; // [RQ16]
	assign rd_ptr     = wr_ptr_reg - span;
	assign past       = history[rd_ptr];
	// one extra bit keeps a full-scale swing from wrapping
	assign delta      = $signed({i_value[15], i_value}) - $signed({past[15], past}); // [RQ15]
	assign level      = $signed({i_value[15], i_value}); // [RQ14]
	assign limit      = $signed({i_threshold[15], i_threshold});
	assign compared   = i_roc ? delta : level;
	assign trip       = i_above ? (compared > limit) : (compared < limit); // [RQ13]
	// no rate-of-change verdict until enough history is held
	assign history_ok = !i_roc || (fill_reg >= span);
	assign hit        = i_enable && history_ok && trip;

	// history is a plain memory, so it carries no reset
	always_ff @(posedge i_clk) begin
		if (i_sample_stb) begin
			history[wr_ptr_reg] <= i_value;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= 8'h00;
			fill_reg   <= 8'h00;
			o_active   <= 1'b0;
			o_hit_stb  <= 1'b0;
		end else begin
			o_hit_stb <= i_sample_stb && hit;
			if (i_sample_stb) begin
				wr_ptr_reg <= wr_ptr_reg + 8'h01;
				if (fill_reg != 8'hFF) begin
					fill_reg <= fill_reg + 8'h01;
				end
				o_active <= hit; // [RQ22]
			end
		end
	end
endmodule
`default_nettype wire

/* File: design/gyro_bias_correction_and_alarms.sv */
// bias correction, calibration restore and two alarms behind a serial register port
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RQ1 - command bit 0 starts automatic offset nulling
// RQ2 - wait full output cycle, negate, store, flash
// RQ3 - stored offset is rate output times minus one
// RQ4 - averaging span follows the decimation setting
// RQ5 - serial port ignores frames while nulling runs
// RQ6 - only reset aborts a running null sequence
// RQ7 - coarse offset is added to rate output
// RQ8 - fine offset extends coarse offset below it
// RQ9 - command bit 1 clears offsets, data, flashes
// RQ10 - two independent alarms with own settings
// RQ11 - four-bit source select per alarm
// RQ12 - config bits pick rate-of-change or static
// RQ13 - polarity bit chooses above or below threshold
// RQ14 - static mode compares source against threshold
// RQ15 - rate mode compares change over sample span
// RQ16 - sample count zero or one means one
// RQ17 - filtered data applies to rate source only
// RQ18 - indicator enable, polarity and line select
// RQ19 - alarm flags appear in status bits nine:eight
// RQ20 - command bits self-clear when function finishes
// RQ21 - registers span two byte addresses, low first
// RQ22 - alarms evaluated once per internal sample
module gyro_bias_correction_and_alarms (
	// clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	// serial register port
	input  wire logic        I_SPI_CS_N,
	input  wire logic        I_SPI_SCLK,
	input  wire logic        I_SPI_DIN,
	output logic             O_SPI_DOUT,
	output logic             O_SPI_DOUT_OE,
	// per-sample data
	input  wire logic        I_SAMPLE_STB,
	input  wire logic [15:0] I_RATE_SAMPLE,
	input  wire logic [15:0] I_RATE_FILT,
	input  wire logic [15:0] I_TEMP,
	// averaged output data
	input  wire logic        I_OUT_STB,
	input  wire logic [15:0] I_RATE_AVG_COARSE,
	input  wire logic [15:0] I_RATE_AVG_FINE,
	input  wire logic [4:0]  I_DECIMATION_SETTING,
	output logic [15:0]      O_RATE_OUTPUT_COARSE,
	output logic [15:0]      O_RATE_OUTPUT_FINE,
	// status and flash
	input  wire logic [15:0] I_STATUS_OTHER,
	output logic [15:0]      O_STATUS_FLAGS,
	output logic             O_CLEAR_DATA,
	output logic             O_FLASH_REQ,
	input  wire logic        I_FLASH_DONE,
	output logic             O_AUTO_NULL_BUSY,
	// alarm indicator lines
	output logic             O_GP_LINE_ONE,
	output logic             O_GP_LINE_ONE_OE,
	output logic             O_GP_LINE_TWO,
	output logic             O_GP_LINE_TWO_OE
);
	// register address match on the word, ignoring the byte bit
	function automatic logic reg_hit(input logic [6:0] addr, input logic [6:0] ofs);
		reg_hit = (addr[6:1] == ofs[6:1]); // [RQ21]
	endfunction

	// byte merge: even address is the low byte, odd the high byte
	function automatic logic [15:0] merge_byte(input logic [15:0] old, input logic upper,
		input logic [7:0] data);
		merge_byte = upper ? {data, old[7:0]} : {old[15:8], data}; // [RQ21]
	endfunction

	// alarm source multiplexer
	function automatic logic [15:0] pick_source(input logic [3:0] sel, input logic [15:0] rate,
		input logic [15:0] temp, input logic [15:0] status);
		if (sel == gyro_corr_pkg::SRC_RATE) begin
			pick_source = rate;
		end else if (sel == gyro_corr_pkg::SRC_TEMP) begin
			pick_source = temp;
		end else if (sel == gyro_corr_pkg::SRC_STATUS) begin
			pick_source = status;
		end else begin
			pick_source = gyro_corr_pkg::REG_RESET;
		end
	endfunction

	// pin synchronisers: cs_n, sclk, din
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic        sclk_prev_reg;
	logic        cs_n_prev_reg;
	logic [15:0] rx_reg;
	logic [15:0] tx_reg;
	logic [15:0] read_data_reg;
	logic [4:0]  bitcnt_reg;

	// user registers
	logic [15:0] threshold_reg [0:1];
	logic [15:0] samples_reg [0:1];
	logic [15:0] alarm_config_reg;
	logic [15:0] offset_coarse_reg;
	logic [15:0] offset_fine_reg;
	logic [1:0]  command_reg;
	logic [1:0]  alarm_flag_reg;

	// sequencer
	gyro_corr_pkg::null_state_e state_reg;
	logic [16:0] avg_count_reg;

	wire        cs_n_s;
	wire        sclk_s;
	wire        din_s;
	wire        busy;
	wire        sclk_rise;
	wire        sclk_fall;
	wire        cs_fall;
	wire        frame_done;
	wire        frame_write;
	wire        frame_read;
	wire [6:0]  frame_addr;
	wire [7:0]  frame_byte;
	wire        frame_upper;
	wire        wr_command;
	wire        start_null;
	wire        start_restore;
	wire [31:0] corrected;
	wire [31:0] negated;
	wire [4:0]  dec_clamped;
	wire [16:0] samples_needed;
	wire [15:0] rate_for_alarm;
	wire [15:0] status_word;
	wire [1:0]  alarm_active;
	wire [1:0]  alarm_hit;
	wire        indicator_level;
	logic [15:0] read_mux;

	assign cs_n_s      = sync2_reg[0];
	assign sclk_s      = sync2_reg[1];
	assign din_s       = sync2_reg[2];
	assign busy        = command_reg[gyro_corr_pkg::CMD_AUTO_NULL];
	assign sclk_rise   = !cs_n_s && !sclk_prev_reg && sclk_s;
	assign sclk_fall   = !cs_n_s && sclk_prev_reg && !sclk_s;
	assign cs_fall     = cs_n_prev_reg && !cs_n_s;
	// a running null sequence leaves the port deaf and mute
	assign frame_done  = !cs_n_prev_reg && cs_n_s && !busy &&
		(bitcnt_reg == 5'(gyro_corr_pkg::FRAME_BITS)); // [RQ5]
	assign frame_write = frame_done && rx_reg[gyro_corr_pkg::FRAME_RW_BIT];
	assign frame_read  = frame_done && !rx_reg[gyro_corr_pkg::FRAME_RW_BIT];
	assign frame_addr  = rx_reg[gyro_corr_pkg::FRAME_ADDR_LSB +: gyro_corr_pkg::ADDR_W];
	assign frame_byte  = rx_reg[gyro_corr_pkg::BYTE_W-1:0];
	assign frame_upper = frame_addr[0];
	assign wr_command  = frame_write && !frame_upper &&
		reg_hit(frame_addr, gyro_corr_pkg::OFS_COMMAND);
	// only an idle sequencer accepts a new command
	assign start_null    = wr_command && (state_reg == gyro_corr_pkg::ST_IDLE) &&
		frame_byte[gyro_corr_pkg::CMD_AUTO_NULL]; // [RQ1]
	assign start_restore = wr_command && (state_reg == gyro_corr_pkg::ST_IDLE) &&
		!frame_byte[gyro_corr_pkg::CMD_AUTO_NULL] && frame_byte[gyro_corr_pkg::CMD_RESTORE];

	assign corrected = {I_RATE_AVG_COARSE, I_RATE_AVG_FINE} +
		{offset_coarse_reg, offset_fine_reg}; // [RQ7] [RQ8]
	assign negated   = 32'h0000_0000 - corrected; // [RQ3]
	assign dec_clamped    = (I_DECIMATION_SETTING > gyro_corr_pkg::DEC_MAX) ?
		gyro_corr_pkg::DEC_MAX : I_DECIMATION_SETTING;
	assign samples_needed = 17'h0_0001 << dec_clamped; // [RQ4]

	assign rate_for_alarm = (alarm_config_reg[gyro_corr_pkg::CFG_FILTER] ?
		I_RATE_FILT : I_RATE_SAMPLE) + offset_coarse_reg; // [RQ17]
	assign status_word = {I_STATUS_OTHER[15:gyro_corr_pkg::STATUS_ALARM_LSB+2], alarm_flag_reg,
		I_STATUS_OTHER[gyro_corr_pkg::STATUS_ALARM_LSB-1:0]}; // [RQ19]
	assign indicator_level = alarm_config_reg[gyro_corr_pkg::CFG_IND_POL] ?
		(|alarm_active) : !(|alarm_active); // [RQ18]

	always_comb begin
		if (reg_hit(frame_addr, gyro_corr_pkg::OFS_OFFSET_FINE)) begin
			read_mux = offset_fine_reg;
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_OFFSET_COARSE)) begin
			read_mux = offset_coarse_reg;
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_THRESHOLD1)) begin
			read_mux = threshold_reg[0];
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_THRESHOLD2)) begin
			read_mux = threshold_reg[1];
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_SAMPLES1)) begin
			read_mux = samples_reg[0];
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_SAMPLES2)) begin
			read_mux = samples_reg[1];
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_ALARM_CONFIG)) begin
			read_mux = alarm_config_reg;
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_STATUS)) begin
			read_mux = status_word;
		end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_COMMAND)) begin
			read_mux = {14'h0000, command_reg};
		end else begin
			read_mux = gyro_corr_pkg::REG_RESET;
		end
	end

	// two alarms, each with its own source, mode, polarity, threshold and count; the filter bit and indicator are shared
	genvar g;
	generate
		for (g = 0; g < gyro_corr_pkg::NUM_ALARMS; g++) begin : g_alarm
			wire [3:0] src_sel;
			assign src_sel = alarm_config_reg[gyro_corr_pkg::CFG_SRC1_LSB +
				g*gyro_corr_pkg::SRC_W +: gyro_corr_pkg::SRC_W]; // [RQ11]
			alarm_channel u_alarm (
				.i_clk        (I_CLK),
				.i_rst        (I_RST),
				.i_sample_stb (I_SAMPLE_STB),
				.i_value      (pick_source(src_sel, rate_for_alarm, I_TEMP, status_word)),
				.i_enable     (src_sel != gyro_corr_pkg::SRC_OFF),
				.i_roc        (alarm_config_reg[gyro_corr_pkg::CFG_ROC_LSB + g]), // [RQ12]
				.i_above      (alarm_config_reg[gyro_corr_pkg::CFG_POL_LSB + g]), // [RQ13]
				.i_threshold  (threshold_reg[g]),
				.i_count      (samples_reg[g][gyro_corr_pkg::COUNT_W-1:0]),
				.o_active     (alarm_active[g]),
				.o_hit_stb    (alarm_hit[g])
			); // [RQ10]
		end
	endgenerate

	// serial port shifter
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sync1_reg     <= 3'h3;
			sync2_reg     <= 3'h3;
			sclk_prev_reg <= 1'b1;
			cs_n_prev_reg <= 1'b1;
			rx_reg        <= gyro_corr_pkg::REG_RESET;
			tx_reg        <= gyro_corr_pkg::REG_RESET;
			read_data_reg <= gyro_corr_pkg::REG_RESET;
			bitcnt_reg    <= 5'h00;
			O_SPI_DOUT_OE <= 1'b0;
		end else begin
			sync1_reg     <= {I_SPI_DIN, I_SPI_SCLK, I_SPI_CS_N};
			sync2_reg     <= sync1_reg;
			sclk_prev_reg <= sclk_s;
			cs_n_prev_reg <= cs_n_s;
			O_SPI_DOUT_OE <= !cs_n_s && !busy; // [RQ5]
			if (cs_fall) begin
				bitcnt_reg <= 5'h00;
				tx_reg     <= read_data_reg;
			end else if (sclk_rise) begin
				rx_reg <= {rx_reg[14:0], din_s};
				if (bitcnt_reg != 5'h1F) begin
					bitcnt_reg <= bitcnt_reg + 5'h01;
				end
			end else if (sclk_fall) begin
				tx_reg <= {tx_reg[14:0], 1'b0};
			end
			// a read frame returns its data during the following frame
			if (frame_read) begin
				read_data_reg <= read_mux;
			end
		end
	end

	// registers, sequencer, flags and outputs
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			threshold_reg[0]     <= gyro_corr_pkg::REG_RESET;
			threshold_reg[1]     <= gyro_corr_pkg::REG_RESET;
			samples_reg[0]       <= gyro_corr_pkg::REG_RESET;
			samples_reg[1]       <= gyro_corr_pkg::REG_RESET;
			alarm_config_reg     <= gyro_corr_pkg::REG_RESET;
			offset_coarse_reg    <= gyro_corr_pkg::REG_RESET;
			offset_fine_reg      <= gyro_corr_pkg::REG_RESET;
			command_reg          <= 2'h0;
			alarm_flag_reg       <= 2'h0;
			state_reg            <= gyro_corr_pkg::ST_IDLE; // [RQ6]
			avg_count_reg        <= 17'h0_0000;
			O_RATE_OUTPUT_COARSE <= gyro_corr_pkg::REG_RESET;
			O_RATE_OUTPUT_FINE   <= gyro_corr_pkg::REG_RESET;
			O_CLEAR_DATA         <= 1'b0;
			O_FLASH_REQ          <= 1'b0;
			O_GP_LINE_ONE        <= 1'b0;
			O_GP_LINE_ONE_OE     <= 1'b0;
			O_GP_LINE_TWO        <= 1'b0;
			O_GP_LINE_TWO_OE     <= 1'b0;
		end else begin
			O_CLEAR_DATA <= 1'b0;
			if (frame_write) begin
				if (reg_hit(frame_addr, gyro_corr_pkg::OFS_OFFSET_FINE)) begin
					offset_fine_reg <= merge_byte(offset_fine_reg, frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_OFFSET_COARSE)) begin
					offset_coarse_reg <= merge_byte(offset_coarse_reg, frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_THRESHOLD1)) begin
					threshold_reg[0] <= merge_byte(threshold_reg[0], frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_THRESHOLD2)) begin
					threshold_reg[1] <= merge_byte(threshold_reg[1], frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_SAMPLES1)) begin
					samples_reg[0] <= merge_byte(samples_reg[0], frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_SAMPLES2)) begin
					samples_reg[1] <= merge_byte(samples_reg[1], frame_upper, frame_byte);
				end else if (reg_hit(frame_addr, gyro_corr_pkg::OFS_ALARM_CONFIG)) begin
					alarm_config_reg <= merge_byte(alarm_config_reg, frame_upper, frame_byte);
				end
			end
			// flags clear on a status read; a hit in that cycle wins
			if (frame_read && reg_hit(frame_addr, gyro_corr_pkg::OFS_STATUS)) begin
				alarm_flag_reg <= alarm_hit;
			end else begin
				alarm_flag_reg <= alarm_flag_reg | alarm_hit; // [RQ19]
			end
			if (I_OUT_STB) begin
				O_RATE_OUTPUT_COARSE <= corrected[31:16];
				O_RATE_OUTPUT_FINE   <= corrected[15:0];
			end
			case (state_reg)
				gyro_corr_pkg::ST_IDLE: begin
					if (start_null) begin
						command_reg[gyro_corr_pkg::CMD_AUTO_NULL] <= 1'b1; // [RQ1]
						state_reg <= gyro_corr_pkg::ST_ALIGN;
					end else if (start_restore) begin
						command_reg[gyro_corr_pkg::CMD_RESTORE] <= 1'b1;
						offset_coarse_reg    <= gyro_corr_pkg::REG_RESET; // [RQ9]
						offset_fine_reg      <= gyro_corr_pkg::REG_RESET;
						O_RATE_OUTPUT_COARSE <= gyro_corr_pkg::REG_RESET;
						O_RATE_OUTPUT_FINE   <= gyro_corr_pkg::REG_RESET;
						O_CLEAR_DATA         <= 1'b1;
						O_FLASH_REQ          <= 1'b1;
						state_reg <= gyro_corr_pkg::ST_FLASH;
					end
				end
				// start counting on an output boundary so the cycle is whole
				gyro_corr_pkg::ST_ALIGN: begin
					avg_count_reg <= 17'h0_0000;
					if (I_OUT_STB) begin
						state_reg <= gyro_corr_pkg::ST_COLLECT; // [RQ2]
					end
				end
				gyro_corr_pkg::ST_COLLECT: begin
					if (avg_count_reg >= samples_needed) begin
						state_reg <= gyro_corr_pkg::ST_CAPTURE; // [RQ4]
					end else if (I_SAMPLE_STB) begin
						avg_count_reg <= avg_count_reg + 17'h0_0001;
					end
				end
				gyro_corr_pkg::ST_CAPTURE: begin
					if (I_OUT_STB) begin
						offset_coarse_reg <= negated[31:16]; // [RQ2] [RQ3]
						offset_fine_reg   <= negated[15:0];
						O_FLASH_REQ       <= 1'b1;
						state_reg         <= gyro_corr_pkg::ST_FLASH;
					end
				end
				gyro_corr_pkg::ST_FLASH: begin
					if (I_FLASH_DONE) begin
						O_FLASH_REQ <= 1'b0;
						command_reg <= 2'h0; // [RQ20]
						state_reg   <= gyro_corr_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= gyro_corr_pkg::ST_IDLE;
				end
			endcase
			if (I_SAMPLE_STB) begin
				O_GP_LINE_ONE    <= indicator_level; // [RQ22]
				O_GP_LINE_TWO    <= indicator_level;
				O_GP_LINE_ONE_OE <= alarm_config_reg[gyro_corr_pkg::CFG_IND_EN] &&
					!alarm_config_reg[gyro_corr_pkg::CFG_IND_SEL]; // [RQ18]
				O_GP_LINE_TWO_OE <= alarm_config_reg[gyro_corr_pkg::CFG_IND_EN] &&
					alarm_config_reg[gyro_corr_pkg::CFG_IND_SEL];
			end
		end
	end

	assign O_SPI_DOUT       = tx_reg[gyro_corr_pkg::FRAME_BITS-1];
	assign O_STATUS_FLAGS   = status_word;
	assign O_AUTO_NULL_BUSY = busy;
endmodule
`default_nettype wire

/* File: tb/gyro_corr_asserts.sv */
// port assertions for the bias correction and alarm block
`timescale 1ns/1ns
`default_nettype none
module gyro_corr_asserts (
	// clock and reset
	input wire logic        I_CLK,
	input wire logic        I_RST,
	// watched ports
	input wire logic        I_SAMPLE_STB,
	input wire logic        I_OUT_STB,
	input wire logic        I_FLASH_DONE,
	input wire logic [15:0] I_STATUS_OTHER,
	input wire logic [15:0] O_STATUS_FLAGS,
	input wire logic [15:0] O_RATE_OUTPUT_COARSE,
	input wire logic        O_SPI_DOUT_OE,
	input wire logic        O_AUTO_NULL_BUSY,
	input wire logic        O_FLASH_REQ,
	input wire logic        O_CLEAR_DATA,
	input wire logic        O_GP_LINE_ONE,
	input wire logic        O_GP_LINE_ONE_OE,
	input wire logic        O_GP_LINE_TWO_OE
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	property p_quiet; O_AUTO_NULL_BUSY |-> !O_SPI_DOUT_OE; endproperty
	a_quiet: assert property (p_quiet) else $error("port driven while nulling");
	property p_req_hold; O_FLASH_REQ && !I_FLASH_DONE |=> O_FLASH_REQ; endproperty
	a_req_hold: assert property (p_req_hold) else $error("flash request dropped");
	property p_no_abort; O_AUTO_NULL_BUSY && !I_FLASH_DONE |=> O_AUTO_NULL_BUSY; endproperty
	a_no_abort: assert property (p_no_abort) else $error("null ended early");
	property p_status;
		O_STATUS_FLAGS[15:10] == I_STATUS_OTHER[15:10] && O_STATUS_FLAGS[7:0] == I_STATUS_OTHER[7:0];
	endproperty
	a_status: assert property (p_status) else $error("status bits wrong");
	property p_flag_time; $rose(O_STATUS_FLAGS[8]) |-> $past(I_SAMPLE_STB, 2); endproperty
	a_flag_time: assert property (p_flag_time) else $error("flag off strobe");
	property p_ind_time; $changed(O_GP_LINE_ONE) |-> $past(I_SAMPLE_STB); endproperty
	a_ind_time: assert property (p_ind_time) else $error("indicator off strobe");
	property p_one_line; !(O_GP_LINE_ONE_OE && O_GP_LINE_TWO_OE); endproperty
	a_one_line: assert property (p_one_line) else $error("both lines driven");
	// clear is a lone pulse and the flash update follows it at once
	property p_clr; O_CLEAR_DATA |=> !O_CLEAR_DATA ##[0:1] O_FLASH_REQ; endproperty
	a_clr: assert property (p_clr) else $error("restore sequence wrong");
	property p_out_time;
		$changed(O_RATE_OUTPUT_COARSE) |-> $past(I_OUT_STB) || O_CLEAR_DATA || $past(O_CLEAR_DATA);
	endproperty
	a_out_time: assert property (p_out_time) else $error("output off strobe");
	c_null: cover property ($rose(O_AUTO_NULL_BUSY));
	c_clear: cover property (O_CLEAR_DATA);
	c_flag: cover property ($rose(O_STATUS_FLAGS[9]));
endmodule
`default_nettype wire

/* File: tb/spi_host_model.sv */
// serial host model: byte frames on a mode 3 serial port
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// clock
	input  wire logic i_clk,
	// serial lines
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din,
	input  wire logic i_dout
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_din  = 1'b0;
	end
	// phases span several cycles so the synchroniser sees each one
	task automatic xfer(input logic [15:0] f, output logic [15:0] r);
		r = 16'h0000;
		@(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		// each fall shifts the next bit out, so the bit is taken just before it
		for (int b = 15; b >= 0; b--) begin
			r[b] = i_dout;
			o_sclk <= 1'b0;
			o_din  <= f[b];
			repeat (4) @(posedge i_clk);
			o_sclk <= 1'b1;
			repeat (4) @(posedge i_clk);
		end
		o_cs_n <= 1'b1;
		o_din  <= ~o_din;
		repeat (6) @(posedge i_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] r;
		xfer({1'b1, a, d[7:0]}, r);
		xfer({1'b1, a + 7'h01, d[15:8]}, r);
	endtask
	// read data comes back during the following frame
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		xfer({1'b0, a, 8'h00}, d);
		xfer({1'b0, a, 8'h00}, d);
	endtask
endmodule
`default_nettype wire

/* File: tb/gyro_bias_correction_and_alarms_tb_top.sv */
// self-checking bench for the bias correction and alarm block
`timescale 1ns/1ns
`default_nettype none
module gyro_bias_correction_and_alarms_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        smp = 1'b0;
	logic        ostb = 1'b0;
	logic        fdone = 1'b0;
	logic [15:0] rate = 16'h0000;
	logic [15:0] temp = 16'h0000;
	logic [4:0]  dec = 5'h00;
	logic [15:0] out_c, out_f, status, d;
	logic        cs_n, sclk, din, dout, dout_oe, freq, busy, g1, g1_oe, g2, g2_oe;
	wire logic   miso;
	int          fails = 0;
	int          n_checks = 0;
	logic [6:0]  regs [7] = '{7'h08, 7'h0A, 7'h10, 7'h12, 7'h14, 7'h16, 7'h18};
	always #50 clk = ~clk;
	// a released line shows the opposite level, never a stale bit
	assign miso = dout_oe ? dout : ~dout;
	gyro_bias_correction_and_alarms dut_u (
		.I_CLK(clk), .I_RST(rst), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk),
		.I_SPI_DIN(din), .O_SPI_DOUT(dout), .O_SPI_DOUT_OE(dout_oe),
		.I_SAMPLE_STB(smp), .I_RATE_SAMPLE(rate), .I_RATE_FILT(16'h0100),
		.I_TEMP(temp), .I_OUT_STB(ostb), .I_RATE_AVG_COARSE(16'h0100),
		.I_RATE_AVG_FINE(16'h8000), .I_DECIMATION_SETTING(dec),
		.O_RATE_OUTPUT_COARSE(out_c), .O_RATE_OUTPUT_FINE(out_f),
		.I_STATUS_OTHER(16'h0301), .O_STATUS_FLAGS(status), .O_CLEAR_DATA(),
		.O_FLASH_REQ(freq), .I_FLASH_DONE(fdone), .O_AUTO_NULL_BUSY(busy),
		.O_GP_LINE_ONE(g1), .O_GP_LINE_ONE_OE(g1_oe), .O_GP_LINE_TWO(g2),
		.O_GP_LINE_TWO_OE(g2_oe)
	);
	spi_host_model h (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din), .i_dout(miso));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input logic s, input logic o, input logic [15:0] r, input logic [15:0] t);
		@(posedge clk);
		smp  <= s;
		ostb <= o;
		rate <= r;
		temp <= t;
		@(posedge clk);
		smp  <= 1'b0;
		ostb <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic wait_flash;
		int k;
		k = 0;
		while (freq !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		if (k == 100) begin
			fails++;
			wrap_up();
		end
		@(posedge clk);
		fdone <= 1'b1;
		@(posedge clk);
		fdone <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		foreach (regs[i]) begin
			h.rd(regs[i], d);
			chk(d, 16'h0000);
			if (regs[i][6:2] != 5'h05) begin
				h.wr(regs[i], {1'b0, regs[i], 1'b1, regs[i]});
				h.rd(regs[i], d);
				chk(d, {1'b0, regs[i], 1'b1, regs[i]});
			end
		end
		h.wr(7'h2A, 16'h1234);
		h.rd(7'h2A, d);
		chk(d, 16'h0000);
		$display("test registers done");
		h.xfer({1'b1, 7'h28, 8'h02}, d);
		wait_flash();
		h.rd(7'h0A, d);
		chk(d, 16'h0000);
		h.rd(7'h10, d);
		chk(d, 16'h1090);
		$display("test restore done");
		h.wr(7'h10, 16'h0100);
		h.wr(7'h12, 16'h0050);
		h.wr(7'h18, 16'h2116);
		tick(1'b1, 1'b0, 16'h0200, 16'h0010);
		@(negedge clk);
		chk(status, 16'h0301);
		tick(1'b1, 1'b0, 16'h0200, 16'h0010);
		@(negedge clk);
		chk({13'h0000, g1, g1_oe, g2_oe}, 16'h0006);
		h.rd(7'h26, d);
		chk(d, 16'h0301);
		// equal values must not trip; the filtered rate is what is compared
		h.wr(7'h18, 16'h211D);
		tick(1'b1, 1'b0, 16'h0200, 16'h0050);
		tick(1'b1, 1'b0, 16'h0200, 16'h0050);
		@(negedge clk);
		chk(status, 16'h0001);
		chk({13'h0000, g2, g2_oe, g1_oe}, 16'h0006);
		h.wr(7'h10, 16'h0020);
		h.wr(7'h14, 16'h0002);
		h.wr(7'h18, 16'h0150);
		tick(1'b1, 1'b0, 16'h0000, 16'h0050);
		tick(1'b1, 1'b0, 16'h0000, 16'h0050);
		@(negedge clk);
		chk(status, 16'h0001);
		tick(1'b1, 1'b0, 16'h0030, 16'h0050);
		@(negedge clk);
		chk(status, 16'h0101);
		$display("test alarms done");
		h.wr(7'h0A, 16'h0010);
		h.wr(7'h08, 16'h8000);
		tick(1'b0, 1'b1, 16'h0000, 16'h0050);
		@(negedge clk);
		chk(out_c, 16'h0111);
		chk(out_f, 16'h0000);
		dec <= 5'h01;
		h.xfer({1'b1, 7'h28, 8'h01}, d);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		h.wr(7'h10, 16'hFFFF);
		tick(1'b0, 1'b1, 16'h0000, 16'h0050);
		tick(1'b1, 1'b0, 16'h0000, 16'h0050);
		// one sample of two: an output strobe now must not capture
		tick(1'b0, 1'b1, 16'h0000, 16'h0050);
		@(negedge clk);
		chk({15'h0000, freq}, 16'h0000);
		tick(1'b1, 1'b0, 16'h0000, 16'h0050);
		tick(1'b0, 1'b1, 16'h0000, 16'h0050);
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0001);
		wait_flash();
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0000);
		h.rd(7'h0A, d);
		chk(d, 16'hFEEF);
		h.rd(7'h10, d);
		chk(d, 16'h0020);
		$display("test null done");
		h.xfer({1'b1, 7'h28, 8'h01}, d);
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({15'h0000, busy}, 16'h0000);
		$display("test abort done");
		wrap_up();
	end
endmodule
bind gyro_bias_correction_and_alarms gyro_corr_asserts ck (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_SAMPLE_STB(I_SAMPLE_STB), .I_OUT_STB(I_OUT_STB),
	.I_FLASH_DONE(I_FLASH_DONE), .I_STATUS_OTHER(I_STATUS_OTHER),
	.O_STATUS_FLAGS(O_STATUS_FLAGS), .O_RATE_OUTPUT_COARSE(O_RATE_OUTPUT_COARSE),
	.O_SPI_DOUT_OE(O_SPI_DOUT_OE), .O_AUTO_NULL_BUSY(O_AUTO_NULL_BUSY),
	.O_FLASH_REQ(O_FLASH_REQ), .O_CLEAR_DATA(O_CLEAR_DATA), .O_GP_LINE_ONE(O_GP_LINE_ONE),
	.O_GP_LINE_ONE_OE(O_GP_LINE_ONE_OE), .O_GP_LINE_TWO_OE(O_GP_LINE_TWO_OE)
);
`default_nettype wire
